// ---- hdl/spi_master_phase1.sv ----
// Serial peripheral master, phase-delayed bit timing, with a transmit FIFO.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Period four clocks, else divisor plus one.
// - Period spans 4-128, or 5-127 odd.
// - Odd period: first phase half clock shorter.
// - Polarity bit selects edge and idle level.
// - Starts and chains words only with master and phase set; a word in progress finishes.
// - Data leads active edge by half bit.
// - Select asserts half bit before first edge.
// - Select releases after last bit, stays back-to-back.
module spi_master_phase1 (
    input  wire logic                                     clock_in,
    input  wire logic                                     reset_n_in,
    input  wire logic                                     low_speed_periph_clock_in,
    input  wire logic [spi_timing_pkg::DIV_WIDTH-1:0]     baud_divisor_in,
    input  wire logic                                     clock_polarity_in,
    input  wire logic                                     master_select_in,
    input  wire logic                                     clock_phase_in,
    input  wire logic [spi_timing_pkg::LEN_WIDTH-1:0]     char_len_in,
    input  wire logic                                     tx_valid_in,
    output logic                                          tx_ready_out,
    input  wire logic [spi_timing_pkg::WORD_WIDTH-1:0]    tx_data_in,
    output logic [spi_timing_pkg::WORD_WIDTH-1:0]         rx_data_out,
    output logic                                          rx_valid_out,
    output logic                                          busy_out,
    output logic                                          serial_bit_clock_out,
    output logic                                          master_out_line_out,
    input  wire logic                                     master_in_line_in,
    output logic                                          slave_select_n_out
);
    localparam int unsigned WW = spi_timing_pkg::WORD_WIDTH;
    localparam int unsigned LW = spi_timing_pkg::LEN_WIDTH;
    localparam int unsigned CW = spi_timing_pkg::CNT_WIDTH;
    localparam int unsigned PW = spi_timing_pkg::PERIOD_WIDTH;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_LEAD    = 4'h2,
        ST_PHASE_A = 4'h4,
        ST_PHASE_B = 4'h8
    } state_t;

    // ****************************************************************
    // Pin synchronisers and half-tick enable
    // ****************************************************************
    logic ls_sync1_q;
    logic ls_sync2_q;
    logic ls_prev_q;
    logic in_sync1_q;
    logic in_sync2_q;
    logic half_tick;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ls_sync1_q <= spi_timing_pkg::LINE_IDLE;
            ls_sync2_q <= spi_timing_pkg::LINE_IDLE;
            ls_prev_q  <= spi_timing_pkg::LINE_IDLE;
            in_sync1_q <= spi_timing_pkg::LINE_IDLE;
            in_sync2_q <= spi_timing_pkg::LINE_IDLE;
        end else begin
            ls_sync1_q <= low_speed_periph_clock_in;
            ls_sync2_q <= ls_sync1_q;
            ls_prev_q  <= ls_sync2_q;
            in_sync1_q <= master_in_line_in;
            in_sync2_q <= in_sync1_q;
        end
    end

    // Both edges of the peripheral clock count, so odd periods split by half clocks.
    always_comb begin
        half_tick = ls_sync2_q ^ ls_prev_q;
    end

    // ****************************************************************
    // Bit-clock period and phase lengths in half peripheral clocks
    // ****************************************************************
    logic [PW-1:0] period;
    logic          period_odd;
    logic [CW-1:0] lead_len;
    logic [CW-1:0] phase_a_len;
    logic [CW-1:0] phase_b_len;

    always_comb begin
        if (baud_divisor_in < spi_timing_pkg::DIV_FLOOR) begin
            period = spi_timing_pkg::MIN_PERIOD;
        end else begin
            period = PW'({1'h0, baud_divisor_in}) + spi_timing_pkg::PERIOD_ONE;
        end
        period_odd = period[0];
        lead_len   = CW'(period);
        if (period_odd) begin
            phase_a_len = CW'(period) - spi_timing_pkg::HALF_TICK_ONE;
            phase_b_len = CW'(period) + spi_timing_pkg::HALF_TICK_ONE;
        end else begin
            phase_a_len = CW'(period);
            phase_b_len = CW'(period);
        end
    end

    // ****************************************************************
    // Transmit FIFO
    // ****************************************************************
    logic          fifo_valid;
    logic          fifo_pop;
    logic [WW-1:0] fifo_data;

    word_fifo #(
        .WIDTH (WW),
        .DEPTH (spi_timing_pkg::FIFO_DEPTH)
    ) tx_fifo (
        .clock_in      (clock_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .in_data_in    (tx_data_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    state_t        state_q;
    state_t        state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [LW-1:0] bit_q;
    logic [LW-1:0] bit_d;
    logic [WW-1:0] tx_word_q;
    logic [WW-1:0] tx_word_d;
    logic [WW-1:0] rx_shift_q;
    logic [WW-1:0] rx_shift_d;
    logic [WW-1:0] rx_data_q;
    logic [WW-1:0] rx_data_d;
    logic          rx_valid_q;
    logic          rx_valid_d;
    logic          sclk_q;
    logic          sclk_d;
    logic          mosi_q;
    logic          mosi_d;
    logic          ss_n_q;
    logic          ss_n_d;
    logic          mode_ok;
    logic          phase_end;
    logic [CW-1:0] cur_len;

    always_comb begin
        mode_ok    = master_select_in && clock_phase_in;
        state_d    = state_q;
        cnt_d      = cnt_q;
        bit_d      = bit_q;
        tx_word_d  = tx_word_q;
        rx_shift_d = rx_shift_q;
        rx_data_d  = rx_data_q;
        rx_valid_d = 1'h0;
        sclk_d     = sclk_q;
        mosi_d     = mosi_q;
        ss_n_d     = ss_n_q;
        fifo_pop   = 1'h0;
        case (state_q)
            ST_LEAD:    cur_len = lead_len;
            ST_PHASE_A: cur_len = phase_a_len;
            default:    cur_len = phase_b_len;
        endcase
        phase_end = half_tick && (cnt_q == cur_len - spi_timing_pkg::HALF_TICK_ONE);
        if (half_tick && !phase_end) begin
            cnt_d = cnt_q + spi_timing_pkg::HALF_TICK_ONE;
        end
        case (state_q)
            ST_IDLE: begin
                sclk_d = clock_polarity_in;
                ss_n_d = spi_timing_pkg::SELECT_IDLE;
                cnt_d  = spi_timing_pkg::CNT_ZERO;
                if (mode_ok && fifo_valid) begin
                    // select and first bit lead by half a period
                    fifo_pop  = 1'h1;
                    tx_word_d = fifo_data;
                    bit_d     = char_len_in;
                    mosi_d    = fifo_data[char_len_in];
                    ss_n_d    = 1'h0;
                    state_d   = ST_LEAD;
                end
            end
            ST_LEAD, ST_PHASE_B: begin
                if (phase_end) begin
                    cnt_d   = spi_timing_pkg::CNT_ZERO;
                    sclk_d  = ~clock_polarity_in;
                    rx_shift_d = {rx_shift_q[WW-2:0], in_sync2_q};
                    state_d = ST_PHASE_A;
                end
            end
            ST_PHASE_A: begin
                if (phase_end) begin
                    cnt_d  = spi_timing_pkg::CNT_ZERO;
                    sclk_d = clock_polarity_in;
                    if (bit_q == spi_timing_pkg::BIT_ZERO) begin
                        rx_valid_d = 1'h1;
                        rx_data_d  = rx_shift_q;
                        if (mode_ok && fifo_valid) begin
                            fifo_pop  = 1'h1;
                            tx_word_d = fifo_data;
                            bit_d     = char_len_in;
                            mosi_d    = fifo_data[char_len_in];
                            state_d   = ST_PHASE_B;
                        end else begin
                            // release together with the trailing edge, half a period after the last active edge
                            ss_n_d  = spi_timing_pkg::SELECT_IDLE;
                            state_d = ST_IDLE;
                        end
                    end else begin
                        // next bit half a period before its edge
                        bit_d   = bit_q - spi_timing_pkg::BIT_ONE;
                        mosi_d  = tx_word_q[bit_q - spi_timing_pkg::BIT_ONE];
                        state_d = ST_PHASE_B;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                ss_n_d  = spi_timing_pkg::SELECT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q    <= ST_IDLE;
            cnt_q      <= spi_timing_pkg::CNT_ZERO;
            bit_q      <= spi_timing_pkg::BIT_ZERO;
            tx_word_q  <= spi_timing_pkg::WORD_ZERO;
            rx_shift_q <= spi_timing_pkg::WORD_ZERO;
            rx_data_q  <= spi_timing_pkg::WORD_ZERO;
            rx_valid_q <= 1'h0;
            sclk_q     <= spi_timing_pkg::LINE_IDLE;
            mosi_q     <= spi_timing_pkg::LINE_IDLE;
            ss_n_q     <= spi_timing_pkg::SELECT_IDLE;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            bit_q      <= bit_d;
            tx_word_q  <= tx_word_d;
            rx_shift_q <= rx_shift_d;
            rx_data_q  <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            sclk_q     <= sclk_d;
            mosi_q     <= mosi_d;
            ss_n_q     <= ss_n_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb begin
        serial_bit_clock_out = sclk_q;
        master_out_line_out  = mosi_q;
        slave_select_n_out   = ss_n_q;
        rx_data_out          = rx_data_q;
        rx_valid_out         = rx_valid_q;
        busy_out             = (state_q != ST_IDLE);
    end
endmodule
`default_nettype wire

// ---- shared/spi_timing_pkg.sv ----
// Constants shared by the phase-delayed serial master and its transmit buffer.
`default_nettype none
package spi_timing_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int unsigned WORD_WIDTH   = 16;
    localparam int unsigned LEN_WIDTH    = 4;
    localparam int unsigned DIV_WIDTH    = 7;
    localparam int unsigned PERIOD_WIDTH = 8;
    localparam int unsigned CNT_WIDTH    = 9;
    localparam int unsigned FIFO_DEPTH   = 16;

    // ****************************************************************
    // Bit-clock period
    // ****************************************************************
    // Divisor values below this give the shortest period.
    localparam logic [DIV_WIDTH-1:0]    DIV_FLOOR     = 7'h03;
    localparam logic [PERIOD_WIDTH-1:0] MIN_PERIOD    = 8'h04;
    localparam logic [PERIOD_WIDTH-1:0] PERIOD_ONE    = 8'h01;
    localparam logic [CNT_WIDTH-1:0]    HALF_TICK_ONE = 9'h001;
    localparam logic [CNT_WIDTH-1:0]    CNT_ZERO      = 9'h000;

    // ****************************************************************
    // Reset and idle values
    // ****************************************************************
    localparam logic                  SELECT_IDLE = 1'h1;
    localparam logic                  LINE_IDLE   = 1'h0;
    localparam logic [LEN_WIDTH-1:0]  BIT_ZERO    = 4'h0;
    localparam logic [LEN_WIDTH-1:0]  BIT_ONE     = 4'h1;
    localparam logic [WORD_WIDTH-1:0] WORD_ZERO   = 16'h0000;
endpackage
`default_nettype wire

// ---- hdl/word_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int unsigned WIDTH = spi_timing_pkg::WORD_WIDTH,
    parameter int unsigned DEPTH = spi_timing_pkg::FIFO_DEPTH
) (
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    wr_d;
    logic [PW-1:0]    rd_q;
    logic [PW-1:0]    rd_d;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready_out  = (count_q != (PW+1)'(DEPTH));
        out_valid_out = (count_q != '0);
        out_data_out  = mem_q[rd_q];
        push          = in_valid_in && in_ready_out;
        pop           = out_valid_out && out_ready_in;
        wr_d          = push ? wr_q + PW'(1) : wr_q;
        rd_d          = pop ? rd_q + PW'(1) : rd_q;
        count_d       = count_q;
        if (push && !pop) begin
            count_d = count_q + (PW+1)'(1);
        end else if (pop && !push) begin
            count_d = count_q - (PW+1)'(1);
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            count_q <= count_d;
        end
    end

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end
endmodule
`default_nettype wire

// ---- verification/spi_master_phase1_props.sv ----
// Port checks for the phase-delayed serial master.
`timescale 1ns/1ps
`default_nettype none
module spi_master_phase1_props (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic clock_polarity_in,
    input wire logic master_select_in,
    input wire logic clock_phase_in,
    input wire logic tx_ready_out,
    input wire logic rx_valid_out,
    input wire logic serial_bit_clock_out,
    input wire logic master_out_line_out,
    input wire logic slave_select_n_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // ****
    // Assertions and covers
    // ****
    sequence act_edge;
        $changed(serial_bit_clock_out) && serial_bit_clock_out != clock_polarity_in;
    endsequence
    a_idle_level: assert property (
        (slave_select_n_out && $stable(clock_polarity_in)) [*3]
        |-> serial_bit_clock_out == clock_polarity_in) else $error("clock not idle");
    a_data_lead: assert property (
        act_edge |-> $past(master_out_line_out, 8) == master_out_line_out
        && $stable(master_out_line_out)) else $error("data late");
    a_data_hold: assert property (
        act_edge |=> $stable(master_out_line_out) [*8]) else $error("data not held");
    a_select_lead: assert property (
        $fell(slave_select_n_out) |-> serial_bit_clock_out == clock_polarity_in
        ##1 $stable(serial_bit_clock_out) [*8]) else $error("select lead short");
    a_select_release: assert property (
        $rose(slave_select_n_out) |-> serial_bit_clock_out == clock_polarity_in
        && $past(serial_bit_clock_out) != clock_polarity_in) else $error("bad release");
    a_start_mode: assert property (
        $fell(slave_select_n_out) |-> master_select_in && clock_phase_in)
        else $error("start out of mode");
    a_phase_min: assert property (
        $changed(serial_bit_clock_out) |=> $stable(serial_bit_clock_out) [*8])
        else $error("phase too short");
    a_rx_pulse: assert property (
        rx_valid_out |-> serial_bit_clock_out == clock_polarity_in
        && $past(serial_bit_clock_out, 2) != clock_polarity_in ##1 !rx_valid_out)
        else $error("receive pulse misplaced");
    c_word: cover property ($fell(slave_select_n_out));
    c_chain: cover property (rx_valid_out && !slave_select_n_out);
    c_full: cover property (!tx_ready_out);
endmodule
bind spi_master_phase1 spi_master_phase1_props u_props (
    .clock_in, .reset_n_in, .clock_polarity_in, .master_select_in, .clock_phase_in,
    .tx_ready_out, .rx_valid_out, .serial_bit_clock_out, .master_out_line_out,
    .slave_select_n_out
);
`default_nettype wire

// ---- verification/serial_slave_model.sv ----
// Behavioural serial slave that replies from a word and keeps the bits it sees.
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model (
    input  wire logic        bit_clock_in,
    input  wire logic        select_n_in,
    input  wire logic        polarity_in,
    input  wire logic        from_master_in,
    input  wire logic [31:0] reply_in,
    output var logic         to_master_out,
    output var logic [15:0]  captured_out
);
    logic [31:0] shift_q;
    initial to_master_out = 1'b0;
    always @(negedge select_n_in) begin
        shift_q = reply_in;
        to_master_out = reply_in[31];
    end
    always @(posedge select_n_in) to_master_out = ~to_master_out;
    always @(bit_clock_in) begin
        if (!select_n_in && bit_clock_in != polarity_in) begin
            captured_out = {captured_out[14:0], from_master_in};
        end else if (!select_n_in) begin
            shift_q = shift_q << 1;
            to_master_out = shift_q[31];
        end
    end
endmodule
`default_nettype wire

// ---- verification/spi_master_phase1_tb.sv ----
// Self-checking bench for the phase-delayed serial master.
`timescale 1ns/1ps
`default_nettype none
module spi_master_phase1_tb;
    logic        clock = 1'b0, lsp_clock = 1'b0, reset_n, pol, msel, cph, valid;
    logic        ready, rxv, busy, sclk, mosi, miso, sel_n;
    logic [6:0]  div;
    logic [3:0]  len;
    logic [15:0] data, rxd, got, w;
    logic [31:0] reply, r;
    int          bad_count, comparisons, cycles, edges, rises, p;
    realtime     t_act, per, ph_a;
    logic [6:0]  divs [6] = '{7'h00, 7'h02, 7'h04, 7'h07, 7'h7e, 7'h7f};
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
    spi_master_phase1 u_dut (.clock_in(clock), .reset_n_in(reset_n),
        .low_speed_periph_clock_in(lsp_clock), .baud_divisor_in(div), .clock_polarity_in(pol),
        .master_select_in(msel), .clock_phase_in(cph), .char_len_in(len), .tx_valid_in(valid),
        .tx_ready_out(ready), .tx_data_in(data), .rx_data_out(rxd), .rx_valid_out(rxv),
        .busy_out(busy), .serial_bit_clock_out(sclk), .master_out_line_out(mosi),
        .master_in_line_in(miso), .slave_select_n_out(sel_n));
    serial_slave_model u_slave (.bit_clock_in(sclk), .select_n_in(sel_n), .polarity_in(pol),
        .from_master_in(mosi), .reply_in(reply), .to_master_out(miso), .captured_out(got));
    initial forever #2.5 clock = ~clock;
    initial #1.3 forever #24 lsp_clock = ~lsp_clock;
    // ****
    // Bit clock timing monitor
    // ****
    always @(negedge sel_n) edges = 0;
    always @(posedge sel_n) rises++;
    always @(sclk) begin
        if (sel_n === 1'b0 && sclk !== pol) begin
            if (edges == 1) per = $realtime - t_act;
            t_act = $realtime;
            edges++;
        end else if (sel_n === 1'b0 && edges == 1) begin
            ph_a = $realtime - t_act;
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic setup(input logic [6:0] d, input logic q, input logic [3:0] l,
                         input logic [31:0] rep);
        // An idle gap keeps a polarity change clear of the last word's final phase.
        repeat (10) @(posedge clock);
        div <= d;
        pol <= q;
        len <= l;
        reply <= rep;
    endtask
    task automatic push(input logic [15:0] v);
        @(posedge clock);
        valid <= 1'b1;
        data <= v;
        @(posedge clock);
        while (ready !== 1'b1) @(posedge clock);
        valid <= 1'b0;
    endtask
    task automatic take();
        do @(posedge clock); while (rxv !== 1'b1);
        w = rxd;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {reset_n, valid, data, div, len, pol, reply} = '0;
        msel = 1'b1;
        cph = 1'b1;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            setup(divs[i], i[0], 4'h7, {8'hc3 ^ 8'(i), 24'h00_0000});
            push(16'h005a ^ 16'(i));
            take();
            p = div < 7'h03 ? 4 : div + 1;
            `CHECK(w[7:0], 8'hc3 ^ 8'(i))
            `CHECK(got[7:0], 8'h5a ^ 8'(i))
            `CHECK(int'(per / 48.0), p)
            `CHECK(int'(ph_a / 24.0), p - p % 2)
            $display("divisor test %0d done", i);
        end
        setup(7'h05, 1'b0, 4'h7, 32'ha53c_0000);
        p = rises;
        push(16'h0012);
        push(16'h0034);
        take();
        `CHECK(w[7:0], 8'ha5)
        take();
        `CHECK(w[7:0], 8'h3c)
        while (busy !== 1'b0) @(posedge clock);
        `CHECK(rises - p, 1)
        `CHECK(got, 16'h1234)
        $display("back-to-back test done");
        cph <= 1'b0;
        setup(7'h03, 1'b1, 4'h3, 32'h9abc_def1);
        for (int i = 0; i < 16; i++) push(16'(i));
        @(posedge clock);
        `CHECK(ready, 1'b0)
        `CHECK(busy, 1'b0)
        msel <= 1'b0;
        cph <= 1'b1;
        repeat (8) @(posedge clock);
        `CHECK(sel_n, 1'b1)
        msel <= 1'b1;
        r = 32'h9abc_def1;
        p = rises;
        for (int i = 0; i < 16; i++) begin
            take();
            `CHECK(w[3:0], r[31:28])
            r = r << 4;
        end
        while (busy !== 1'b0) @(posedge clock);
        `CHECK(ready, 1'b1)
        `CHECK(rises - p, 1)
        `CHECK(got, 16'hcdef)
        $display("buffer test done");
        wrap_up();
    end
endmodule
`default_nettype wire
